// >>> hw/scm_dev.sv
// Device end: serial management slave with its first three registers.
// Assumes the link lines arrive unsynchronised; loader and detect logic
// run on the same clock.
`timescale 1ns/10ps
`default_nettype none
module scm_dev (
   input wire logic clk_in,
   input wire logic rst_n_in,
   scm_if.dev link,
   input wire logic serial_mgmt_enable_strap_in,
   input wire logic [3:0] addr_sel_in,
   input wire logic eeprom_load_done_in,
   input wire logic power_down_pin_in,
   input wire logic rx_detect_auto_reset_in,
   output logic [7:0] channel_power_down_bits_out,
   output logic rx_detect_reset_out,
   output logic bus_idle_out
);
   import scm_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RECV = 3'b001,
      ST_ACK = 3'b010,
      ST_SEND = 3'b011,
      ST_MACK = 3'b100,
      ST_WAIT = 3'b101
   } scm_dst_t;

   typedef enum logic [1:0] {
      K_ADDR = 2'b00,
      K_INDEX = 2'b01,
      K_DATA = 2'b10
   } scm_kind_t;

   typedef struct packed {
      logic [1:0] scl_sy;
      logic [1:0] sda_sy;
      logic scl_p;
      logic sda_p;
      logic [1:0][3:0] ad_sy;
      logic [1:0] en_sy;
      logic [1:0] pdp_sy;
      scm_dst_t st;
      scm_kind_t kind;
      logic rw;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] idx;
      logic mack;
      logic stop_seen;
      logic [IDLE_W-1:0] idle_cnt;
      logic idle;
      logic [7:0] obs_rw;
      logic [7:0] chan_pd;
      logic [7:0] ovr;
      logic sda_oe;
      logic [7:0] pd_out;
      logic rxd_rst;
   } scm_dev_st_t;

   scm_dev_st_t q;
   scm_dev_st_t n;
   logic scl;
   logic sda;
   logic start_ev;
   logic stop_ev;
   logic scl_rise;
   logic scl_fall;
   logic idle_hit;
   logic [6:0] my_addr;

   // Register read mux; writable reserved bits read back as stored
   function automatic logic [7:0] rd_reg(input scm_dev_st_t s,
                                         input logic done);
      logic [7:0] v;
      v = 8'h00;
      case (s.idx)
         REG_PIN_LOAD_OBS: begin
            v = s.obs_rw & OBS_RW_MASK;
            v[OBS_PIN_LSB +: 4] = s.ad_sy[1];
            v[OBS_LOAD_DONE_BIT] = done;
         end
         REG_CHAN_PD: v = s.chan_pd;
         REG_PRES_PWR_OVR: v = s.ovr;
         default: v = 8'h00;
      endcase
      return v;
   endfunction : rd_reg

   // Only the second synchroniser stage is looked at
   assign scl = q.scl_sy[1];
   assign sda = q.sda_sy[1];
   assign start_ev = scl & q.scl_p & q.sda_p & ~sda;
   assign stop_ev = scl & q.scl_p & ~q.sda_p & sda;
   assign scl_rise = scl & ~q.scl_p;
   assign scl_fall = ~scl & q.scl_p;
   // Pins read zero when open, so default address is 0x58
   assign my_addr = ADDR_BASE + {3'b000, q.ad_sy[1]};
   // Bus-free after a stop, otherwise longest clock-high
   assign idle_hit = q.stop_seen ?
                     (q.idle_cnt >= IDLE_W'(BUF_CYC)) :
                     (q.idle_cnt >= IDLE_W'(HIGH_MAX_CYC));

   // Next-state logic for the whole device end
   always_comb begin
      n = q;
      n.scl_sy = {q.scl_sy[0], link.scl_line};
      n.sda_sy = {q.sda_sy[0], link.sda_line};
      n.ad_sy = {q.ad_sy[0], addr_sel_in};
      n.en_sy = {q.en_sy[0], serial_mgmt_enable_strap_in};
      n.pdp_sy = {q.pdp_sy[0], power_down_pin_in};
      n.scl_p = scl;
      n.sda_p = sda;
      // Both lines high: count, saturating
      if (scl & sda) begin
         if (q.idle_cnt != {IDLE_W{1'b1}}) begin
            n.idle_cnt = q.idle_cnt + 1'b1;
         end
      end else begin
         n.idle_cnt = '0;
      end
      // Start wins over everything; stop and idle release the line
      if (start_ev) begin
         n.st = q.en_sy[1] ? ST_RECV : ST_IDLE;
         n.kind = K_ADDR;
         n.cnt = 4'h0;
         n.sda_oe = 1'b0;
         n.stop_seen = 1'b0;
         n.idle = 1'b0;
      end else if (stop_ev) begin
         n.st = ST_IDLE;
         n.sda_oe = 1'b0;
         n.stop_seen = 1'b1;
      end else if (idle_hit) begin
         n.st = ST_IDLE;
         n.sda_oe = 1'b0;
         n.idle = 1'b1;
      end else if (scl_rise) begin
         // Sample only while clock high, data already stable
         if (q.st == ST_RECV) begin
            n.sh = {q.sh[6:0], sda};
            n.cnt = q.cnt + 4'h1;
         end else if (q.st == ST_MACK) begin
            n.mack = ~sda;
         end
      end else if (scl_fall) begin
         // Line changes only just after a falling clock
         unique case (q.st)
            ST_RECV: begin
               if (q.cnt == 4'h8) begin
                  n.sda_oe = 1'b1;
                  n.st = ST_ACK;
                  if (q.kind == K_ADDR) begin
                     n.rw = q.sh[0];
                     if (q.sh[7:1] != my_addr) begin
                        n.sda_oe = 1'b0;
                        n.st = ST_WAIT;
                     end
                  end else if (q.kind == K_INDEX) begin
                     n.idx = q.sh;
                  end else begin
                     // Read-only fields are never stored
                     case (q.idx)
                        REG_PIN_LOAD_OBS: n.obs_rw = q.sh & OBS_RW_MASK;
                        REG_CHAN_PD: n.chan_pd = q.sh;
                        REG_PRES_PWR_OVR: n.ovr = q.sh;
                        default: n.obs_rw = q.obs_rw;
                     endcase
                  end
               end
            end
            ST_ACK: begin
               n.cnt = 4'h0;
               if (q.kind == K_ADDR && q.rw == DIR_READ) begin
                  n.sh = rd_reg(q, eeprom_load_done_in);
                  n.sda_oe = ~n.sh[7];
                  n.sh = {n.sh[6:0], 1'b0};
                  n.cnt = 4'h1;
                  n.st = ST_SEND;
               end else begin
                  n.sda_oe = 1'b0;
                  n.st = ST_RECV;
                  n.kind = (q.kind == K_ADDR) ? K_INDEX : K_DATA;
               end
            end
            ST_SEND: begin
               if (q.cnt == 4'h8) begin
                  n.sda_oe = 1'b0;
                  n.st = ST_MACK;
               end else begin
                  n.sda_oe = ~q.sh[7];
                  n.sh = {q.sh[6:0], 1'b0};
                  n.cnt = q.cnt + 4'h1;
               end
            end
            ST_MACK: begin
               // Host nack ends the read; an ack repeats the register
               if (q.mack) begin
                  n.sh = rd_reg(q, eeprom_load_done_in);
                  n.sda_oe = ~n.sh[7];
                  n.sh = {n.sh[6:0], 1'b0};
                  n.cnt = 4'h1;
                  n.st = ST_SEND;
               end else begin
                  n.st = ST_WAIT;
               end
            end
            ST_IDLE, ST_WAIT: n.sda_oe = 1'b0;
            default: begin
               n.st = ST_IDLE;
               n.sda_oe = 1'b0;
            end
         endcase
      end
      // Register control of power down only under override
      n.pd_out = q.ovr[OVR_PWR_BIT] ? q.chan_pd :
                 {8{q.pdp_sy[1]}};
      n.rxd_rst = q.ovr[OVR_PRES_BIT] ? q.ovr[OVR_PRES_VAL_BIT] :
                  rx_detect_auto_reset_in;
   end

   // One register stage for all state
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         q <= '0;
         // Lines idle high; avoids a false clock edge after reset
         q.scl_sy <= 2'h3;
         q.sda_sy <= 2'h3;
         q.scl_p <= 1'h1;
         q.sda_p <= 1'h1;
         q.obs_rw <= OBS_RST;
         q.chan_pd <= CHAN_PD_RST;
         q.ovr <= OVR_RST;
      end else begin
         q <= n;
      end
   end

   // Open drain: drive low only, enable marks driving
   assign link.dev_sda_o = 1'b0;
   assign link.dev_sda_oe = q.sda_oe;
   assign channel_power_down_bits_out = q.pd_out;
   assign rx_detect_reset_out = q.rxd_rst;
   assign bus_idle_out = q.idle;
endmodule : scm_dev
`default_nettype wire

// >>> common/scm_pkg.sv
// Constants shared by both ends of the serial management port.
// Assumes a single 50 MHz system clock on both ends.
package scm_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int CLK_MHZ = CLK_HZ / 1_000_000;
   // Bus-free time after a stop, least figure, in ns
   localparam int T_BUF_NS = 4700;
   // Longest clock-high time, in ns
   localparam int T_HIGH_MAX_NS = 50000;
   // Least time rounds up, longest time rounds down
   localparam int BUF_CYC = (T_BUF_NS * CLK_MHZ + 999) / 1000;
   localparam int HIGH_MAX_CYC = (T_HIGH_MAX_NS * CLK_MHZ) / 1000;
   localparam int IDLE_W = 12;
   // Host serial clock rate, one bit is four quarter phases
   localparam int SCL_HZ = 100_000;
   localparam int QTR_CYC = CLK_HZ / (4 * SCL_HZ);
   localparam int QTR_W = 7;
   localparam logic [QTR_W-1:0] QTR_LAST = QTR_W'(QTR_CYC - 1);
   // Slave address is base plus the four select pins
   localparam logic [6:0] ADDR_BASE = 7'h58;
   localparam logic DIR_WRITE = 1'b0;
   localparam logic DIR_READ = 1'b1;
   // Register indices
   localparam logic [7:0] REG_PIN_LOAD_OBS = 8'h00;
   localparam logic [7:0] REG_CHAN_PD = 8'h01;
   localparam logic [7:0] REG_PRES_PWR_OVR = 8'h02;
   // Field positions
   localparam int OBS_PIN_LSB = 3;
   localparam int OBS_LOAD_DONE_BIT = 2;
   localparam logic [7:0] OBS_RW_MASK = 8'h83;
   localparam int OVR_PRES_BIT = 7;
   localparam int OVR_PRES_VAL_BIT = 6;
   localparam int OVR_PWR_BIT = 0;
   // Values after reset, then the all-ones byte the host sends while reading
   localparam logic [7:0] OBS_RST = 8'h00;
   localparam logic [7:0] CHAN_PD_RST = 8'h00;
   localparam logic [7:0] OVR_RST = 8'h00;
   localparam logic [7:0] IDLE_BYTE = 8'hFF;
endpackage : scm_pkg

// >>> common/scm_if.sv
// Two-wire link joining the host end and the device end.
// Lines are open drain with pull-ups; an enable pulls a line low.
`timescale 1ns/10ps
`default_nettype none
interface scm_if;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic scl_line;
   logic sda_line;
   // Wired-AND of all drivers, pull-up gives high
   assign scl_line = ~(host_scl_oe & ~host_scl_o);
   assign sda_line = ~((host_sda_oe & ~host_sda_o) |
                       (dev_sda_oe & ~dev_sda_o));
   modport dev (input scl_line, input sda_line,
                output dev_sda_o, output dev_sda_oe);
   modport host (input scl_line, input sda_line,
                 output host_scl_o, output host_scl_oe,
                 output host_sda_o, output host_sda_oe);
endinterface : scm_if
`default_nettype wire

// >>> hw/scm_host.sv
// Host end: bus master issuing single register writes and reads.
// Assumes a device that never stretches the clock.
`timescale 1ns/10ps
`default_nettype none
module scm_host (
   input wire logic clk_in,
   input wire logic rst_n_in,
   scm_if.host link,
   input wire logic cmd_valid_in,
   input wire logic cmd_read_in,
   input wire logic [6:0] cmd_addr_in,
   input wire logic [7:0] cmd_index_in,
   input wire logic [7:0] cmd_wdata_in,
   output logic busy_out,
   output logic done_out,
   output logic nack_out,
   output logic [7:0] rdata_out
);
   import scm_pkg::*;

   typedef enum logic [1:0] {
      H_IDLE = 2'b00,
      H_START = 2'b01,
      H_BIT = 2'b10,
      H_STOP = 2'b11
   } scm_hst_t;

   typedef enum logic [2:0] {
      S_ADDRW = 3'b000,
      S_INDEX = 3'b001,
      S_WDATA = 3'b010,
      S_ADDRR = 3'b011,
      S_RDATA = 3'b100
   } scm_step_t;

   typedef struct packed {
      logic [1:0] sda_sy;
      scm_hst_t st;
      scm_step_t step;
      logic [QTR_W-1:0] qcnt;
      logic [1:0] ph;
      logic [3:0] bitn;
      logic [7:0] sh;
      logic [7:0] rx;
      logic rd;
      logic [6:0] addr;
      logic [7:0] idx;
      logic [7:0] wdata;
      logic nack;
      logic busy;
      logic done;
      logic scl_oe;
      logic sda_oe;
      logic [7:0] rdata;
   } scm_host_st_t;

   scm_host_st_t q;
   scm_host_st_t n;
   logic tick;

   // Byte sent in each step; reads send all ones to free the line
   function automatic logic [7:0] step_byte(input scm_host_st_t s,
                                            input scm_step_t k);
      logic [7:0] b;
      b = IDLE_BYTE;
      case (k)
         S_ADDRW: b = {s.addr, DIR_WRITE};
         S_INDEX: b = s.idx;
         S_WDATA: b = s.wdata;
         S_ADDRR: b = {s.addr, DIR_READ};
         default: b = IDLE_BYTE;
      endcase
      return b;
   endfunction : step_byte

   assign tick = q.busy && (q.qcnt == QTR_LAST);

   // Quarter-bit sequencer
   always_comb begin
      n = q;
      n.sda_sy = {q.sda_sy[0], link.sda_line};
      n.done = 1'b0;
      if (q.busy) begin
         n.qcnt = tick ? '0 : q.qcnt + 1'b1;
      end
      if (q.st == H_IDLE) begin
         if (cmd_valid_in) begin
            n.st = H_START;
            n.step = S_ADDRW;
            n.rd = cmd_read_in;
            n.addr = cmd_addr_in;
            n.idx = cmd_index_in;
            n.wdata = cmd_wdata_in;
            n.nack = 1'b0;
            n.busy = 1'b1;
            n.qcnt = '0;
            n.ph = 2'b00;
         end
      end else if (tick) begin
         n.ph = q.ph + 2'b01;
         unique case (q.st)
            H_START: begin
               // Data falls while clock high
               unique case (q.ph)
                  2'b00: n.sda_oe = 1'b0;
                  2'b01: n.scl_oe = 1'b0;
                  2'b10: n.sda_oe = 1'b1;
                  2'b11: begin
                     n.scl_oe = 1'b1;
                     n.st = H_BIT;
                     n.bitn = 4'h0;
                     n.sh = step_byte(q, q.step);
                  end
               endcase
            end
            H_BIT: begin
               unique case (q.ph)
                  // Data set only while clock low
                  2'b00: n.sda_oe = (q.bitn == 4'h8) ? 1'b0 : ~q.sh[7];
                  2'b01: n.scl_oe = 1'b0;
                  2'b10: begin
                     if (q.bitn == 4'h8) begin
                        n.nack = q.sda_sy[1] & (q.step != S_RDATA);
                     end else begin
                        n.rx = {q.rx[6:0], q.sda_sy[1]};
                        n.sh = {q.sh[6:0], 1'b1};
                     end
                  end
                  2'b11: begin
                     n.scl_oe = 1'b1;
                     n.bitn = q.bitn + 4'h1;
                     if (q.bitn == 4'h8) begin
                        n.bitn = 4'h0;
                        if (q.nack || q.step == S_WDATA) begin
                           n.st = H_STOP;
                        end else if (q.step == S_RDATA) begin
                           n.rdata = q.rx;
                           n.st = H_STOP;
                        end else if (q.step == S_INDEX && q.rd) begin
                           n.step = S_ADDRR;
                           n.st = H_START;
                        end else begin
                           n.step = (q.step == S_ADDRW) ? S_INDEX :
                                    (q.step == S_INDEX) ? S_WDATA :
                                    S_RDATA;
                           n.sh = step_byte(q, n.step);
                        end
                     end
                  end
               endcase
            end
            H_STOP: begin
               // Data rises while clock high
               unique case (q.ph)
                  2'b00: n.sda_oe = 1'b1;
                  2'b01: n.scl_oe = 1'b0;
                  2'b10: n.sda_oe = 1'b0;
                  2'b11: begin
                     n.st = H_IDLE;
                     n.busy = 1'b0;
                     n.done = 1'b1;
                  end
               endcase
            end
            default: n.st = H_IDLE;
         endcase
      end
   end

   // One register stage for all state
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign link.host_scl_o = 1'b0;
   assign link.host_scl_oe = q.scl_oe;
   assign link.host_sda_o = 1'b0;
   assign link.host_sda_oe = q.sda_oe;
   assign busy_out = q.busy;
   assign done_out = q.done;
   assign nack_out = q.nack;
   assign rdata_out = q.rdata;
endmodule : scm_host
`default_nettype wire

// >>> testbench/scm_properties.sv
// Concurrent checks on the link between host end and device end.
// Assumes the link signals and the device idle flag as plain inputs.
`timescale 1ns/10ps
`default_nettype none
module scm_properties (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic host_sda_oe,
   input wire logic dev_sda_oe,
   input wire logic scl_line,
   input wire logic sda_line,
   input wire logic bus_idle_out
);
   import scm_pkg::*;
   logic scl_q;
   logic sda_q;
   logic after_stop_q;
   logic [7:0] since_fall_q;
   logic [15:0] hi_cnt_q;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // Cycles since clock fall, cycles both lines high, last event a stop
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         after_stop_q <= 1'b0;
         since_fall_q <= 8'hFF;
         hi_cnt_q <= 16'h0000;
      end else begin
         scl_q <= scl_line;
         sda_q <= sda_line;
         if (scl_q && !scl_line) since_fall_q <= 8'h00;
         else if (since_fall_q != 8'hFF) since_fall_q <= since_fall_q + 8'h01;
         // Saturate so a long idle never wraps back to a threshold
         if (!(scl_line && sda_line)) hi_cnt_q <= 16'h0000;
         else if (hi_cnt_q != 16'hFFFF) hi_cnt_q <= hi_cnt_q + 16'h0001;
         if (scl_line && scl_q && !sda_q && sda_line) after_stop_q <= 1'b1;
         else if (scl_line && sda_q && !sda_line) after_stop_q <= 1'b0;
      end
   end
   property p_dev_hold;
      $changed(dev_sda_oe) |-> !scl_line;
   endproperty
   a_dev_hold: assert property (p_dev_hold)
      else $error("device data moved while clock high");
   property p_host_quiet;
      $changed(host_sda_oe) && scl_line |-> !dev_sda_oe;
   endproperty
   a_host_quiet: assert property (p_host_quiet)
      else $error("host start or stop while device drives data");
   property p_dev_lag;
      $changed(dev_sda_oe) |-> since_fall_q <= 8'h08;
   endproperty
   a_dev_lag: assert property (p_dev_lag)
      else $error("device data change too late after clock fall");
   property p_ack_stands;
      $rose(dev_sda_oe) |-> (dev_sda_oe && !scl_line) [*8];
   endproperty
   a_ack_stands: assert property (p_ack_stands)
      else $error("device low drive did not stand");
   property p_start_host;
      $fell(sda_line) && scl_line |-> $rose(host_sda_oe);
   endproperty
   a_start_host: assert property (p_start_host)
      else $error("start not made by host");
   property p_stop_host;
      $rose(sda_line) && scl_line |-> $fell(host_sda_oe);
   endproperty
   a_stop_host: assert property (p_stop_host)
      else $error("stop not made by host");
   property p_idle_clear;
      $fell(sda_line) && scl_line |-> ##[1:8] !bus_idle_out;
   endproperty
   a_idle_clear: assert property (p_idle_clear)
      else $error("idle flag kept after start");
   property p_idle_set;
      hi_cnt_q == (after_stop_q ? BUF_CYC + 10 : HIGH_MAX_CYC + 10)
         |-> bus_idle_out;
   endproperty
   a_idle_set: assert property (p_idle_set)
      else $error("idle flag missing after high time");
   property p_idle_early;
      $rose(bus_idle_out) |-> hi_cnt_q >= (after_stop_q ? BUF_CYC : HIGH_MAX_CYC);
   endproperty
   a_idle_early: assert property (p_idle_early)
      else $error("idle flag raised too early");
   c_ack: cover property ($rose(dev_sda_oe));
   c_start: cover property ($fell(sda_line) && scl_line);
   c_idle: cover property ($rose(bus_idle_out));
endmodule : scm_properties
`default_nettype wire

// >>> testbench/smbus_slave_config_port_tb.sv
// Self-checking bench: host end and device end joined over the link.
// Assumes package, link interface and both design ends compile first.
`timescale 1ns/10ps
`default_nettype none
module smbus_slave_config_port_tb;
   import scm_pkg::*;
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic strap = 1'b1;
   logic [3:0] sel;
   logic load_done, pd_pin, auto_rst;
   logic cmd_valid = 1'b0;
   logic cmd_read = 1'b0;
   logic [6:0] cmd_addr = 7'h00;
   logic [7:0] cmd_index = 8'h00;
   logic [7:0] cmd_wdata = 8'h00;
   logic busy, done, nack, bus_idle, rxd_rst;
   logic [7:0] rdata, pd_bits;
   logic [7:0] wv;
   int err_total = 0;
   int samples_checked = 0;
   int cycles = 0;
   integer seed = 48;
   int m_reg [3] = '{0, 0, 0}; // Register model, index 0 to 2
   scm_if scm_if_i ();
   scm_dev scm_dev_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(scm_if_i),
      .serial_mgmt_enable_strap_in(strap), .addr_sel_in(sel),
      .eeprom_load_done_in(load_done), .power_down_pin_in(pd_pin),
      .rx_detect_auto_reset_in(auto_rst),
      .channel_power_down_bits_out(pd_bits),
      .rx_detect_reset_out(rxd_rst), .bus_idle_out(bus_idle));
   scm_host scm_host_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .link(scm_if_i), .cmd_valid_in(cmd_valid), .cmd_read_in(cmd_read),
      .cmd_addr_in(cmd_addr), .cmd_index_in(cmd_index),
      .cmd_wdata_in(cmd_wdata), .busy_out(busy), .done_out(done),
      .nack_out(nack), .rdata_out(rdata));
   scm_properties scm_properties_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .host_sda_oe(scm_if_i.host_sda_oe), .dev_sda_oe(scm_if_i.dev_sda_oe),
      .scl_line(scm_if_i.scl_line), .sda_line(scm_if_i.sda_line),
      .bus_idle_out(bus_idle));
   // Free-running system clock
   initial begin
      forever #10 clk_in = ~clk_in;
   end
   // Hang guard; the whole run needs some 92000 cycles
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 97000) begin
         err_total++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : end_of_test
   task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk8
   task automatic chk1(input string nm, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %b seen %b", nm, e, g);
      end
   endtask : chk1
   // Let synchronisers and output flops catch up, land past the edge
   task automatic settle();
      repeat (10) @(posedge clk_in);
      #1;
   endtask : settle
   // Channel and detect outputs against the model
   task automatic chk_out();
      chk8("pd_bits", m_reg[2][0] ? 8'(m_reg[1]) : {8{pd_pin}}, pd_bits);
      chk1("rxd_rst", m_reg[2][7] ? m_reg[2][6] : auto_rst, rxd_rst);
   endtask : chk_out
   // One host command; valid held over the taking edge only
   task automatic xfer(input logic rd, input logic [6:0] a,
                       input logic [7:0] ix, input logic [7:0] wd);
      int n;
      @(posedge clk_in);
      #1;
      cmd_valid = 1'b1;
      cmd_read = rd;
      cmd_addr = a;
      cmd_index = ix;
      cmd_wdata = wd;
      @(posedge clk_in);
      #1;
      cmd_valid = 1'b0;
      chk1("busy", 1'b1, busy);
      n = 0;
      while (done !== 1'b1 && n < 30000) begin
         @(posedge clk_in);
         #1;
         n++;
      end
      chk1("busy", 1'b0, busy);
      if (n >= 30000) err_total++;
   endtask : xfer
   // Main sequence
   initial begin
      sel = 4'($random(seed));
      load_done = 1'($random(seed));
      pd_pin = 1'($random(seed));
      auto_rst = 1'($random(seed));
      repeat (10) @(posedge clk_in);
      #1;
      rst_n_in = 1'b1;
      // No stop seen yet, so idle needs the longest clock-high time
      repeat (HIGH_MAX_CYC + 20) @(posedge clk_in);
      #1;
      chk1("bus_idle", 1'b1, bus_idle);
      chk_out();
      wv = 8'($random(seed));
      xfer(1'b0, ADDR_BASE + 7'(sel), REG_CHAN_PD, wv);
      m_reg[1] = wv;
      chk1("nack", 1'b0, nack);
      settle();
      chk_out();
      xfer(1'b0, ADDR_BASE + 7'(sel), REG_PRES_PWR_OVR, 8'hC1);
      m_reg[2] = 8'hC1;
      chk1("nack", 1'b0, nack);
      pd_pin = ~pd_pin;
      auto_rst = ~auto_rst;
      settle();
      chk_out();
      // Override kept, detect reset value now released
      xfer(1'b0, ADDR_BASE + 7'(sel), REG_PRES_PWR_OVR, 8'h81);
      m_reg[2] = 8'h81;
      auto_rst = 1'b1;
      settle();
      chk_out();
      wv = {1'b0, ~sel, ~load_done, 2'b00};
      xfer(1'b0, ADDR_BASE + 7'(sel), REG_PIN_LOAD_OBS, wv);
      m_reg[0] = wv & OBS_RW_MASK;
      chk1("nack", 1'b0, nack);
      xfer(1'b1, ADDR_BASE + 7'(sel), REG_PIN_LOAD_OBS, 8'h00);
      chk8("rdata", {m_reg[0][7], sel, load_done, 2'(m_reg[0])}, rdata);
      chk1("nack", 1'b0, nack);
      repeat (BUF_CYC + 20) @(posedge clk_in);
      #1;
      chk1("bus_idle", 1'b1, bus_idle);
      // Neighbouring address must be left alone
      xfer(1'b0, (ADDR_BASE + 7'(sel)) ^ 7'h01, REG_CHAN_PD, 8'(~m_reg[1]));
      chk1("nack", 1'b1, nack);
      settle();
      chk_out();
      strap = 1'b0;
      settle();
      xfer(1'b0, ADDR_BASE + 7'(sel), REG_CHAN_PD, 8'(~m_reg[1]));
      chk1("nack", 1'b1, nack);
      settle();
      chk_out();
      end_of_test();
   end
endmodule : smbus_slave_config_port_tb
`default_nettype wire
